// *** inc/hw_monitor_pkg.sv ***
`default_nettype none
package hw_monitor_pkg;
   localparam int SYS_HZ        = 20_000_000;
   localparam int CLK_NS        = 50;
   localparam int STROBE_OVL_NS = 50;
   localparam int STROBE_OVL_CYC = (STROBE_OVL_NS + CLK_NS - 1) / CLK_NS;
   localparam int FAN_CLK_HZ    = 22_500;
   localparam int FAN_TICK_CYC  = SYS_HZ / FAN_CLK_HZ;
   localparam int SLOT_MS       = 90;
   localparam int SLOT_CYC      = SLOT_MS * (SYS_HZ / 1000);
   localparam int SLOT_COUNT    = 11;
   // Host port offsets
   localparam logic [2:0] PORT_ADDR = 3'h5;
   localparam logic [2:0] PORT_DATA = 3'h6;
   // Internal register indexes
   localparam logic [6:0] IDX_CFG    = 7'h40;
   localparam logic [6:0] IDX_STAT1  = 7'h41;
   localparam logic [6:0] IDX_STAT2  = 7'h42;
   localparam logic [6:0] IDX_SMIM1  = 7'h43;
   localparam logic [6:0] IDX_SMIM2  = 7'h44;
   localparam logic [6:0] IDX_NMIM1  = 7'h45;
   localparam logic [6:0] IDX_NMIM2  = 7'h46;
   localparam logic [6:0] IDX_FANDIV = 7'h47;
   localparam logic [6:0] IDX_SERADR = 7'h48;
   localparam logic [6:0] IDX_CHIPID = 7'h49;
   localparam logic [6:0] IDX_VRAM_A = 7'h20;
   localparam logic [6:0] IDX_VRAM_B = 7'h60;
   localparam logic [4:0] SLOT_BASE  = 5'h00;
   // Power-on values
   localparam logic [7:0] CFG_RST    = 8'h08;
   localparam logic [7:0] NMIM2_RST  = 8'h40;
   localparam logic [7:0] FANDIV_RST = 8'h50;
   localparam logic [7:0] SERADR_RST = 8'h2d;
   localparam logic [7:0] CHIPID_RST = 8'h40;
   localparam logic [1:0] FAN3_DIV_CODE = 2'h1;
   // Configuration bit positions
   localparam int CFG_START    = 0;
   localparam int CFG_SMI_EN   = 1;
   localparam int CFG_IRQ_EN   = 2;
   localparam int CFG_INT_CLR  = 3;
   localparam int CFG_IRQ_POL  = 5;
   localparam int CFG_BYPASS   = 6;
   localparam int CFG_INIT     = 7;
   localparam int ID_FULL_RST  = 5;
   localparam int FAN1_DIV_LSB = 4;
   localparam int FAN2_DIV_LSB = 6;
endpackage
`default_nettype wire

// *** src/hw_monitor_control_sequencer.sv ***
// Contract
// - Power-up loads control reset values, ADC idle, value RAM undefined.
// - Config bit 7 write reinitialises control, status, mask, divisor registers; self-clears.
// - Serial address register restored only by full power-on reset.
// - Writing one to chip id bit 5 causes full power-on reset.
// - Chip id bit 6 reads high on this full-reset variant.
// - Both strobes low with select high for 50 ns gives full reset.
// - After power-up ADC stopped, interrupt clear asserted, interrupt outputs inactive.
// - Config bit 0 runs loop; low means shutdown, registers still accessible.
// - Config bit 1 enables system management interrupt output.
// - Config bit 2 enables combined interrupt output.
// - Config bit 5 picks combined output polarity: low active-low, high active-high.
// - Host starts with bit 3 low, bit 0 high; loop about once a second.
// - Pass order: temperature, five positive, two inverting, fans one to three.
// - Value read returns latest result and restarts current conversion.
// - ADC gives 8-bit codes, 16 mV step, 0 V to 4.08 V.
// - Fan input gates 22.5 kHz clock into 8-bit counter, scaled by divisor.
// - Fan one and two divisors programmable 1, 2, 4, 8; default 2.
// - Fan three divisor fixed at 2.
// - Bypass control high drives bypass output low.
// - Bypass control sits in config bit 6.
// - Interrupt clear bit high halts loop; low resumes it.
`default_nettype none
module hw_monitor_control_sequencer #(
   parameter int SLOT_CYCLES = hw_monitor_pkg::SLOT_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       portSelect,
   input  wire logic [2:0] portAddr,
   input  wire logic       io_write_strobe_n,
   input  wire logic       io_read_strobe_n,
   input  wire logic [7:0] dataIn,
   output logic      [7:0] dataOut,
   output logic            dataOe,
   input  wire logic [7:0] adcCode,
   output logic      [3:0] adcChannel,
   output logic            adcRun,
   input  wire logic [2:0] fanTach,
   output logic            system_mgmt_irq_out_n,
   output logic            combinedIrqOut,
   output logic            powerBypass_n
);
   import hw_monitor_pkg::*;

   typedef struct packed {
      logic [16:0]      s1;
      logic [16:0]      s2;
      logic [1:0]       strobePrev;
      logic [3:0]       ovlCnt;
      logic [7:0]       cfg;
      logic [7:0]       stat1;
      logic [7:0]       stat2;
      logic [7:0]       smiM1;
      logic [7:0]       smiM2;
      logic [7:0]       nmiM1;
      logic [7:0]       nmiM2;
      logic [7:0]       fanDiv;
      logic [7:0]       serAddr;
      logic [6:0]       ptr;
      logic [31:0][7:0] vram;
      logic [3:0]       slot;
      logic [23:0]      slotTimer;
      logic [9:0]       tickDiv;
      logic [2:0]       tachPrev;
      logic [2:0][2:0]  preCnt;
      logic [2:0][7:0]  fanCnt;
      logic [2:0][7:0]  fanRes;
      logic [7:0]       rdData;
   } state_t;

   // Control registers to power-on values; full reset also restores serial address
   function automatic state_t ctrlInit(input state_t cur, input logic full);
      state_t r;
      r        = cur;
      r.cfg    = CFG_RST;
      r.stat1  = '0;
      r.stat2  = '0;
      r.smiM1  = '0;
      r.smiM2  = '0;
      r.nmiM1  = '0;
      r.nmiM2  = NMIM2_RST;
      r.fanDiv = FANDIV_RST;
      r.slot   = '0;
      r.slotTimer = '0;
      if (full) begin
         r.serAddr = SERADR_RST;
         r.ptr     = '0;
      end
      return r;
   endfunction

   localparam state_t RESET_STATE = ctrlInit('0, 1'b1);

   state_t s;
   state_t next_s;

   logic       selS, wrS, rdS;
   logic [2:0] tachS;
   logic [2:0] addrS;
   logic [7:0] dataS;
   logic       wrRise, rdFall, ovlHit, loopRun, slotEnd, tick, vramRead;
   logic       anySmi, anyNmi, irqActive;
   logic [4:0] vIdx;

   assign {selS, wrS, rdS, tachS, addrS, dataS} = s.s2;
   assign wrRise   = selS && wrS && !s.strobePrev[1] && rdS;
   assign rdFall   = selS && !rdS && s.strobePrev[0] && wrS;
   assign ovlHit   = selS && !wrS && !rdS && (s.ovlCnt >= 4'(STROBE_OVL_CYC - 1));
   assign loopRun  = s.cfg[CFG_START] && !s.cfg[CFG_INT_CLR];
   assign slotEnd  = loopRun && (s.slotTimer == 24'(SLOT_CYCLES - 1));
   assign tick     = (s.tickDiv == 10'(FAN_TICK_CYC - 1));
   assign vIdx     = s.ptr[4:0];
   assign vramRead = rdFall && (addrS == PORT_DATA) && (s.ptr[6:5] == 2'b01 || s.ptr[6:5] == 2'b11);

   always_comb begin
      next_s            = s;
      next_s.s1         = {portSelect, io_write_strobe_n, io_read_strobe_n, fanTach,
                           portAddr, dataIn};
      next_s.s2         = s.s1;
      next_s.strobePrev = {wrS, rdS};
      next_s.ovlCnt     = (selS && !wrS && !rdS) ? s.ovlCnt + 4'h1 : 4'h0;
      next_s.tickDiv    = tick ? 10'h000 : s.tickDiv + 10'h001;
      next_s.tachPrev   = tachS;

      for (int f = 0; f < 3; f++) begin
         logic [1:0] code;
         code = (f == 0) ? s.fanDiv[FAN1_DIV_LSB +: 2] :
                (f == 1) ? s.fanDiv[FAN2_DIV_LSB +: 2] : FAN3_DIV_CODE;
         if (tachS[f] && !s.tachPrev[f]) begin
            next_s.fanRes[f] = s.fanCnt[f];
            next_s.fanCnt[f] = '0;
            next_s.preCnt[f] = '0;
         end else if (tick) begin
            if (s.preCnt[f] == 3'((4'h1 << code) - 4'h1)) begin
               next_s.preCnt[f] = '0;
               if (s.fanCnt[f] != 8'hff)
                  next_s.fanCnt[f] = s.fanCnt[f] + 8'h01;
            end else begin
               next_s.preCnt[f] = s.preCnt[f] + 3'h1;
            end
         end
      end

      if (loopRun) begin
         next_s.slotTimer = slotEnd ? 24'h00_0000 : s.slotTimer + 24'h00_0001;
         if (slotEnd) begin
            next_s.vram[SLOT_BASE + 5'(s.slot)] =
               (s.slot >= 4'h8) ? s.fanRes[s.slot - 4'h8] : adcCode;
            next_s.slot = (s.slot == 4'(SLOT_COUNT - 1)) ? 4'h0 : s.slot + 4'h1;
         end
      end else begin
         next_s.slotTimer = '0;
      end

      if (vramRead)
         next_s.slotTimer = '0;

      if (rdFall) begin
         if (addrS == PORT_ADDR)
            next_s.rdData = {1'b0, s.ptr};
         else
            case (s.ptr)
               IDX_CFG:    next_s.rdData = s.cfg;
               IDX_STAT1:  next_s.rdData = s.stat1;
               IDX_STAT2:  next_s.rdData = s.stat2;
               IDX_SMIM1:  next_s.rdData = s.smiM1;
               IDX_SMIM2:  next_s.rdData = s.smiM2;
               IDX_NMIM1:  next_s.rdData = s.nmiM1;
               IDX_NMIM2:  next_s.rdData = s.nmiM2;
               IDX_FANDIV: next_s.rdData = s.fanDiv;
               IDX_SERADR: next_s.rdData = s.serAddr;
               IDX_CHIPID: next_s.rdData = CHIPID_RST;
               default:    next_s.rdData = (s.ptr[5]) ? s.vram[vIdx] : 8'h00;
            endcase
      end

      if (wrRise && addrS == PORT_ADDR)
         next_s.ptr = dataS[6:0];
      if (wrRise && addrS == PORT_DATA) begin
         case (s.ptr)
            IDX_CFG:    next_s.cfg = {1'b0, dataS[6:0]};
            IDX_STAT1:  next_s.stat1 = dataS;
            IDX_STAT2:  next_s.stat2 = dataS;
            IDX_SMIM1:  next_s.smiM1 = dataS;
            IDX_SMIM2:  next_s.smiM2 = dataS;
            IDX_NMIM1:  next_s.nmiM1 = dataS;
            IDX_NMIM2:  next_s.nmiM2 = dataS;
            IDX_FANDIV: next_s.fanDiv = {dataS[7:4], 4'h0};
            IDX_SERADR: next_s.serAddr = dataS;
            IDX_CHIPID: ;
            default: begin
               if (s.ptr[5])
                  next_s.vram[vIdx] = dataS;
            end
         endcase
         if (s.ptr == IDX_CFG && dataS[CFG_INIT])
            next_s = ctrlInit(next_s, 1'b0);
         if (s.ptr == IDX_CHIPID && dataS[ID_FULL_RST])
            next_s = ctrlInit(next_s, 1'b1);
      end

      if (ovlHit)
         next_s = ctrlInit(next_s, 1'b1);
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset)
         s <= RESET_STATE;
      else
         s <= next_s;
   end

   assign anySmi    = |{s.stat1 & s.smiM1, s.stat2 & s.smiM2};
   assign anyNmi    = |{s.stat1 & s.nmiM1, s.stat2 & s.nmiM2};
   assign irqActive = s.cfg[CFG_IRQ_EN] && !s.cfg[CFG_INT_CLR] && anyNmi;

   assign system_mgmt_irq_out_n = !(s.cfg[CFG_SMI_EN] && !s.cfg[CFG_INT_CLR] && anySmi);
   assign combinedIrqOut = s.cfg[CFG_IRQ_POL] ? irqActive : !irqActive;
   assign powerBypass_n  = !s.cfg[CFG_BYPASS];
   assign dataOut        = s.rdData;
   assign dataOe         = selS && !rdS && wrS;
   assign adcChannel     = s.slot;
   assign adcRun         = loopRun;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence cfgWrite;
      wrRise && addrS == PORT_DATA && s.ptr == IDX_CFG;
   endsequence

   sequence idWrite;
      wrRise && addrS == PORT_DATA && s.ptr == IDX_CHIPID;
   endsequence

   shutdown_hold_a: assert property (!loopRun |=> $stable(s.slot))
      else $error("slot advanced in shutdown");
   clear_halt_a: assert property (s.cfg[CFG_INT_CLR] |-> !adcRun)
      else $error("loop runs with interrupt clear set");
   smi_gate_a: assert property (!s.cfg[CFG_SMI_EN] |-> system_mgmt_irq_out_n)
      else $error("management interrupt active while disabled");
   irq_gate_a: assert property (!s.cfg[CFG_IRQ_EN] |-> combinedIrqOut == !s.cfg[CFG_IRQ_POL])
      else $error("combined interrupt active while disabled");
   irq_polarity_a: assert property (irqActive |-> combinedIrqOut == s.cfg[CFG_IRQ_POL])
      else $error("combined interrupt polarity wrong");
   bypass_drive_a: assert property (cfgWrite ##0 !dataS[CFG_INIT] |=> powerBypass_n == !$past(dataS[CFG_BYPASS]))
      else $error("bypass output not following control");
   soft_init_a: assert property (cfgWrite ##0 dataS[CFG_INIT] |=> s.cfg == CFG_RST && s.fanDiv == FANDIV_RST)
      else $error("soft initialisation incomplete");
   serial_keep_a: assert property ((cfgWrite ##0 dataS[CFG_INIT] && !ovlHit) |=> $stable(s.serAddr))
      else $error("serial address changed by soft init");
   id_reset_a: assert property (idWrite ##0 dataS[ID_FULL_RST] |=> s.serAddr == SERADR_RST && s.cfg == CFG_RST)
      else $error("chip id reset missed");
   strobe_reset_a: assert property (ovlHit |=> s.cfg == CFG_RST && s.serAddr == SERADR_RST)
      else $error("strobe overlap reset missed");
   read_restart_a: assert property (vramRead && !ovlHit |=> s.slotTimer == 24'h00_0000)
      else $error("value read did not restart conversion");
   slot_wrap_a: assert property (slotEnd && s.slot == 4'(SLOT_COUNT - 1) |=> s.slot == 4'h0)
      else $error("pass order did not wrap after fan three");
   fan_sat_a: assert property (s.fanCnt[0] == 8'hff && !(tachS[0] && !s.tachPrev[0]) |=> s.fanCnt[0] == 8'hff)
      else $error("fan counter wrapped");
endmodule // hw_monitor_control_sequencer
`default_nettype wire

// *** tb/host_port_model.sv ***
`default_nettype none
module host_port_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] dataOut,
   output var logic        portSelect,
   output var logic  [2:0] portAddr,
   output var logic        io_write_strobe_n,
   output var logic        io_read_strobe_n,
   output var logic  [7:0] dataIn
);
   timeunit 1ns;
   timeprecision 1ns;
   import hw_monitor_pkg::*;
   initial begin
      portSelect = 1'b0;
      portAddr = 3'h0;
      io_write_strobe_n = 1'b1;
      io_read_strobe_n = 1'b1;
      dataIn = 8'h00;
   end
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #5;
   endtask
   task automatic portWr(input logic [2:0] a, input logic [7:0] d);
      step(1);
      portSelect = 1'b1;
      portAddr = a;
      dataIn = d;
      io_write_strobe_n = 1'b0;
      step(4);
      io_write_strobe_n = 1'b1;
      step(3);
      portSelect = 1'b0;
      dataIn = ~d;
      step(4);
   endtask
   task automatic portRd(input logic [2:0] a, output logic [7:0] d);
      step(1);
      portSelect = 1'b1;
      portAddr = a;
      io_read_strobe_n = 1'b0;
      step(5);
      d = dataOut;
      io_read_strobe_n = 1'b1;
      step(3);
      portSelect = 1'b0;
      step(4);
   endtask
   task automatic regWr(input logic [6:0] idx, input logic [7:0] d);
      portWr(PORT_ADDR, {1'b0, idx});
      portWr(PORT_DATA, d);
   endtask
   task automatic regRd(input logic [6:0] idx, output logic [7:0] d);
      portWr(PORT_ADDR, {1'b0, idx});
      portRd(PORT_DATA, d);
   endtask
   task automatic overlap();
      step(1);
      portSelect = 1'b1;
      io_write_strobe_n = 1'b0;
      io_read_strobe_n = 1'b0;
      step(3);
      io_write_strobe_n = 1'b1;
      io_read_strobe_n = 1'b1;
      step(1);
      portSelect = 1'b0;
      step(8);
   endtask
endmodule // host_port_model
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import hw_monitor_pkg::*;
   typedef struct packed {logic [6:0] idx; logic [7:0] val;} reg_row_t;
   localparam reg_row_t ROWS [7] = '{'{IDX_CFG, CFG_RST}, '{IDX_STAT1, 8'h00},
      '{IDX_SMIM1, 8'h00}, '{IDX_NMIM2, NMIM2_RST}, '{IDX_FANDIV, FANDIV_RST},
      '{IDX_SERADR, SERADR_RST}, '{IDX_CHIPID, CHIPID_RST}};
   logic       sys_clk = 1'b0;
   logic       reset = 1'b1;
   logic       portSelect, io_write_strobe_n, io_read_strobe_n;
   logic [2:0] portAddr;
   logic [7:0] dataIn, dataOut, adcCode, d;
   logic [3:0] adcChannel, lastCh;
   logic       adcRun, lastRun, system_mgmt_irq_out_n, combinedIrqOut, powerBypass_n;
   logic [2:0] fanTach = 3'h0;
   int         errors = 0;
   int         samples_checked = 0;
   always #25 sys_clk = ~sys_clk;
   assign adcCode = {4'hA, adcChannel};
   hw_monitor_control_sequencer #(.SLOT_CYCLES(20)) i_hw_monitor_control_sequencer (
      .sys_clk(sys_clk), .reset(reset), .portSelect(portSelect), .portAddr(portAddr),
      .io_write_strobe_n(io_write_strobe_n), .io_read_strobe_n(io_read_strobe_n),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(), .adcCode(adcCode),
      .adcChannel(adcChannel), .adcRun(adcRun), .fanTach(fanTach),
      .system_mgmt_irq_out_n(system_mgmt_irq_out_n), .combinedIrqOut(combinedIrqOut),
      .powerBypass_n(powerBypass_n));
   host_port_model i_host_port_model (
      .sys_clk(sys_clk), .dataOut(dataOut), .portSelect(portSelect), .portAddr(portAddr),
      .io_write_strobe_n(io_write_strobe_n), .io_read_strobe_n(io_read_strobe_n),
      .dataIn(dataIn));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rr(input logic [6:0] idx, input logic [7:0] exp);
      i_host_port_model.regRd(idx, d);
      check(d, exp);
   endtask
   task automatic wr(input logic [6:0] idx, input logic [7:0] v);
      i_host_port_model.regWr(idx, v);
   endtask
   task automatic pins(input logic [7:0] exp);
      check({4'h0, powerBypass_n, system_mgmt_irq_out_n, combinedIrqOut, adcRun}, exp);
   endtask
   task automatic close_out();
      if (errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Slot order while the loop keeps running
   always @(negedge sys_clk) begin
      if (!reset && adcRun && lastRun && adcChannel !== lastCh) begin
         check({4'h0, adcChannel}, (lastCh == 4'd10) ? 8'h00 : {4'h0, lastCh} + 8'h01);
      end
      lastCh <= adcChannel;
      lastRun <= adcRun;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      #5 reset = 1'b0;
      pins(8'h0E);
      foreach (ROWS[i]) begin
         rr(ROWS[i].idx, ROWS[i].val);
      end
      wr(IDX_CFG, 8'h01);
      pins(8'h0F);
      i_host_port_model.step(250);
      for (int n = 0; n < 8; n++) begin
         rr(IDX_VRAM_A + 7'(n), 8'hA0 + 8'(n));
      end
      rr(IDX_VRAM_B + 7'd3, 8'hA3);
      wr(IDX_STAT1, 8'h01);
      wr(IDX_SMIM1, 8'h01);
      wr(IDX_NMIM1, 8'h01);
      wr(IDX_CFG, 8'h07);
      pins(8'h09);
      wr(IDX_CFG, 8'h25);
      pins(8'h0F);
      wr(IDX_CFG, 8'h0F);
      pins(8'h0E);
      wr(IDX_CFG, 8'h43);
      pins(8'h03);
      wr(IDX_SERADR, 8'h12);
      wr(IDX_FANDIV, 8'hF0);
      rr(IDX_FANDIV, 8'hF0);
      wr(IDX_CFG, 8'h80);
      rr(IDX_CFG, CFG_RST);
      rr(IDX_FANDIV, FANDIV_RST);
      rr(IDX_STAT1, 8'h00);
      rr(IDX_SMIM1, 8'h00);
      rr(IDX_SERADR, 8'h12);
      wr(IDX_CHIPID, 8'h20);
      rr(IDX_SERADR, SERADR_RST);
      wr(IDX_SERADR, 8'h12);
      wr(IDX_CFG, 8'h41);
      i_host_port_model.overlap();
      rr(IDX_SERADR, SERADR_RST);
      rr(IDX_CFG, CFG_RST);
      pins(8'h0E);
      // Fans one and three, divisor two: six or seven ticks give a count of three
      i_host_port_model.step(1);
      fanTach = 3'h5;
      i_host_port_model.step(10);
      fanTach = 3'h0;
      i_host_port_model.step(6 * FAN_TICK_CYC + 100);
      fanTach = 3'h5;
      i_host_port_model.step(10);
      fanTach = 3'h0;
      wr(IDX_CFG, 8'h01);
      i_host_port_model.step(250);
      rr(IDX_VRAM_A + 7'd8, 8'h03);
      rr(IDX_VRAM_A + 7'd10, 8'h03);
      close_out();
   end
endmodule // tb
`default_nettype wire
